// ==== rs_rail_sup.sv ====
// per-rail supervision: on/off source, sequencing, good, limits, input roles
// assumes sense samples arrive from logic on the same clock; pins are async
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module rs_rail_sup #(
	parameter int unsigned STEP_CYC = rs_pkg::STEP_CYC
) (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  wb_cyc,
	input  wire logic                  wb_stb,
	input  wire logic                  wb_we,
	input  wire logic [7:0]            wb_adr,
	input  wire logic [3:0]            wb_sel,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack,
	input  wire logic                  sense_valid,
	input  wire logic [4:0]            sense_rail,
	input  wire logic [rs_pkg::LW-1:0] sense_code,
	input  wire logic                  control_line,
	input  wire logic [rs_pkg::NR-1:0] general_input,
	output logic      [rs_pkg::NR-1:0] rail_en,
	output logic      [rs_pkg::NR-1:0] margin_hi,
	output logic      [rs_pkg::NR-1:0] margin_lo,
	output logic      [2:0]            pin_state,
	output logic                       pmbus_fast,
	output logic                       alert_o,
	output logic                       alert_oe_b
);
	localparam int NR = rs_pkg::NR;
	// ****************************************
	// storage
	// ****************************************
	logic [4:0]              sel_q;
	rs_pkg::rs_cfg_s         cfg_q [NR];
	rs_pkg::rs_roles_s       roles_q;
	logic [NR-1:0]           op_q, pol_q, def_q, frole_q, crole_q;
	logic [NR-1:0]           drail_q [NR];
	logic [NR-1:0]           don_q [NR];
	logic [NR-1:0]           doff_q [NR];
	rs_pkg::rs_lim_t         cur_q [NR];
	rs_pkg::rs_lim_t         tgt_q [NR];
	logic [rs_pkg::LW-1:0]   sp_q [NR];
	logic [3:0]              st_q [NR];
	logic [7:0]              dly_q [NR];
	logic [NR-1:0]           pg_q, seen_q, en_q, foff_q, arm_q, mhi_q, mlo_q;
	logic                    infault_q, fast_q, ctl_s1, ctl_s2;
	logic [NR-1:0]           gi_s1, gi_s2, act_q;
	logic [2:0]              ps_q;
	logic [31:0]             tick_cnt_q;
	logic                    tick;
	logic [31:0]             rd, wv, bm;
	logic                    req, wr;
	logic [NR-1:0]           act, src, c_on, c_off, fedge, cedge;
	logic [3:0]              evt;
	logic                    uv_mask, vin_low, mg_on, mg_lo;
	logic [2:0]              ps_d;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctl_s1 <= 1'b0;
			ctl_s2 <= 1'b0;
			gi_s1  <= '0;
			gi_s2  <= '0;
			act_q  <= '0;
		end else begin
			ctl_s1 <= control_line;
			ctl_s2 <= ctl_s1;
			gi_s1  <= general_input;
			gi_s2  <= gi_s1;
			act_q  <= act;
		end
	end
	assign act   = gi_s2 ^ pol_q;
	assign fedge = act_q & ~act & frole_q;
	assign cedge = act & crole_q;

	// ****************************************
	// 400 us step tick
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) tick_cnt_q <= '0;
		else if (tick) tick_cnt_q <= '0;
		else tick_cnt_q <= tick_cnt_q + 32'h1;
	end
	assign tick = (tick_cnt_q == 32'(STEP_CYC - 1));

	// ****************************************
	// wishbone slave
	// ****************************************
	assign req = wb_cyc & wb_stb & ~wb_ack;
	assign wr  = req & wb_we;
	assign bm  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
	assign wv  = (rd & ~bm) | (wb_dat_i & bm);
	always_comb begin
		rd = 32'h0;
		unique case (wb_adr)
			rs_pkg::R_CTRL:  rd = {26'h0, fast_q, sel_q};
			rs_pkg::R_CFG:   rd = {18'h0, cfg_q[sel_q]};
			rs_pkg::R_OPER:  rd = {8'h0, op_q};
			rs_pkg::R_POL:   rd = {8'h0, pol_q};
			rs_pkg::R_DEF:   rd = {8'h0, def_q};
			rs_pkg::R_FROLE: rd = {8'h0, frole_q};
			rs_pkg::R_CROLE: rd = {8'h0, crole_q};
			rs_pkg::R_ROLES: rd = {14'h0, roles_q};
			rs_pkg::R_SETPT: rd = {20'h0, sp_q[sel_q]};
			rs_pkg::R_DRAIL: rd = {8'h0, drail_q[sel_q]};
			rs_pkg::R_DON:   rd = {8'h0, don_q[sel_q]};
			rs_pkg::R_DOFF:  rd = {8'h0, doff_q[sel_q]};
			rs_pkg::R_STAT:  rd = {27'h0, infault_q, st_q[sel_q]};
			rs_pkg::R_GOOD:  rd = {8'h0, pg_q};
			rs_pkg::R_ENAB:  rd = {8'h0, en_q};
			default: begin
				if (wb_adr[7:5] == rs_pkg::R_LIMB[7:5] && wb_adr[1:0] == 2'h0)
					rd = {20'h0, cur_q[sel_q][wb_adr[4:2]]};
			end
		endcase
	end
	// unmapped addresses ack with zero data and ignore writes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack   <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack   <= req;
			wb_dat_o <= req ? rd : 32'h0;
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sel_q   <= '0;
			fast_q  <= 1'b0;
			op_q    <= '0;
			pol_q   <= '0;
			def_q   <= '0;
			frole_q <= '0;
			crole_q <= '0;
			roles_q <= '0;
			for (int r = 0; r < NR; r++) begin
				cfg_q[r]   <= '0;
				drail_q[r] <= '0;
				don_q[r]   <= '0;
				doff_q[r]  <= '0;
			end
		end else if (wr) begin
			unique case (wb_adr)
				rs_pkg::R_CTRL: begin
					sel_q  <= (wv[4:0] < 5'(NR)) ? wv[4:0] : sel_q;
					fast_q <= wv[5];
				end
				rs_pkg::R_CFG:   cfg_q[sel_q] <= rs_pkg::rs_cfg_s'(wv[13:0]);
				rs_pkg::R_OPER:  op_q <= wv[NR-1:0];
				rs_pkg::R_POL:   pol_q <= wv[NR-1:0];
				rs_pkg::R_DEF:   def_q <= wv[NR-1:0];
				rs_pkg::R_FROLE: frole_q <= wv[NR-1:0];
				rs_pkg::R_CROLE: crole_q <= wv[NR-1:0];
				rs_pkg::R_ROLES: roles_q <= rs_pkg::rs_roles_s'(wv[17:0]);
				rs_pkg::R_DRAIL: drail_q[sel_q] <= wv[NR-1:0];
				rs_pkg::R_DON:   don_q[sel_q] <= wv[NR-1:0];
				rs_pkg::R_DOFF:  doff_q[sel_q] <= wv[NR-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// limit windows and scaling steps
	// ****************************************
	logic       sp_wr, lim_wr, sp_up;
	logic [2:0] lim_k;
	assign sp_wr  = wr && wb_adr == rs_pkg::R_SETPT;
	assign lim_wr = wr && wb_adr[7:5] == rs_pkg::R_LIMB[7:5] && wb_adr[1:0] == 2'h0;
	assign lim_k  = wb_adr[4:2];
	assign sp_up  = wv[11:0] > sp_q[sel_q];
	// in scaling mode software loads targets first and the setpoint write commits them; otherwise a limit write loads at once
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int r = 0; r < NR; r++) begin
				cur_q[r] <= '0;
				tgt_q[r] <= '0;
				sp_q[r]  <= '0;
			end
			arm_q <= '0;
		end else begin
			for (int r = 0; r < NR; r++) begin
				if (tick && arm_q[r]) begin
					arm_q[r] <= (cur_q[r] != tgt_q[r]);
					for (int k = 0; k < 8; k++) begin
						if (tgt_q[r][k] - cur_q[r][k] > rs_pkg::STEP_CODE
						    && tgt_q[r][k] > cur_q[r][k])
							cur_q[r][k] <= cur_q[r][k] + rs_pkg::STEP_CODE;
						else if (cur_q[r][k] - tgt_q[r][k] > rs_pkg::STEP_CODE
						    && cur_q[r][k] > tgt_q[r][k])
							cur_q[r][k] <= cur_q[r][k] - rs_pkg::STEP_CODE;
						else
							cur_q[r][k] <= tgt_q[r][k];
					end
				end
			end
			if (lim_wr) begin
				tgt_q[sel_q][lim_k] <= wv[11:0];
				if (!cfg_q[sel_q].adaptive_scaling_mode)
					cur_q[sel_q][lim_k] <= wv[11:0];
			end
			if (sp_wr) begin
				sp_q[sel_q] <= wv[11:0];
				if (!cfg_q[sel_q].adaptive_scaling_mode) begin
					cur_q[sel_q] <= tgt_q[sel_q];
				end else if (sp_up) begin
					arm_q[sel_q] <= 1'b1;
					cur_q[sel_q][rs_pkg::L_OVF] <= tgt_q[sel_q][rs_pkg::L_OVF];
					cur_q[sel_q][rs_pkg::L_OVW] <= tgt_q[sel_q][rs_pkg::L_OVW];
				end else begin
					arm_q[sel_q] <= 1'b1;
					for (int k = rs_pkg::L_UVW; k <= rs_pkg::L_PGOFF; k++)
						cur_q[sel_q][k] <= tgt_q[sel_q][k];
				end
			end
		end
	end

	// ****************************************
	// sample events, masking, status
	// ****************************************
	rs_pkg::rs_lim_t sl;
	logic            sv;
	assign sv      = sense_valid && sense_rail < 5'(NR) && cfg_q[sense_rail].has_sense;
	assign sl      = cur_q[sense_rail];
	assign vin_low = roles_q.vin_en && !pg_q[roles_q.vin_rail];
	assign uv_mask = !en_q[sense_rail] || !seen_q[sense_rail]
	                 || (vin_low && sense_rail != roles_q.vin_rail);
	always_comb begin
		evt = 4'h0;
		if (sv) begin
			evt[rs_pkg::S_OVF] = sense_code > sl[rs_pkg::L_OVF];
			evt[rs_pkg::S_OVW] = sense_code > sl[rs_pkg::L_OVW];
			evt[rs_pkg::S_UVW] = !uv_mask && sense_code < sl[rs_pkg::L_UVW];
			evt[rs_pkg::S_UVF] = !uv_mask && sense_code < sl[rs_pkg::L_UVF];
		end
	end
	logic       st_wr;
	logic [3:0] st_keep;
	assign st_wr   = wr && wb_adr == rs_pkg::R_STAT;
	assign st_keep = (st_wr && sense_rail == sel_q) ? ~(wb_dat_i[3:0] & bm[3:0]) : 4'hf;
	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int r = 0; r < NR; r++) st_q[r] <= '0;
			infault_q <= 1'b0;
		end else begin
			for (int r = 0; r < NR; r++) begin
				if (|cedge) st_q[r] <= '0;
				else if (st_wr && r == int'(sel_q))
					st_q[r] <= st_q[r] & ~(wb_dat_i[3:0] & bm[3:0]);
				if (sv && r == int'(sense_rail))
					st_q[r] <= (|cedge ? 4'h0 : st_q[r] & st_keep) | evt;
			end
			if (|fedge) infault_q <= 1'b1;
			else if (|cedge || (st_wr && wb_dat_i[4] && bm[4])) infault_q <= 1'b0;
		end
	end
	logic alert_d;
	always_comb begin
		alert_d = infault_q;
		for (int r = 0; r < NR; r++) alert_d = alert_d | (|st_q[r]);
	end

	// ****************************************
	// on/off decision and sequencing
	// ****************************************
	always_comb begin
		for (int r = 0; r < NR; r++) begin
			unique case (cfg_q[r].mode)
				rs_pkg::RS_AUTO: src[r] = 1'b1;
				rs_pkg::RS_PIN:  src[r] = ctl_s2;
				rs_pkg::RS_CMD:  src[r] = op_q[r];
				rs_pkg::RS_BOTH: src[r] = ctl_s2 & op_q[r];
			endcase
			c_on[r]  = &(~drail_q[r] | pg_q) & &(~don_q[r] | act);
			c_off[r] = &(~drail_q[r] | ~pg_q) & &(~doff_q[r] | ~act);
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			en_q <= '0;
			for (int r = 0; r < NR; r++) dly_q[r] <= '0;
		end else begin
			for (int r = 0; r < NR; r++) begin
				if ((src[r] & ~foff_q[r]) != en_q[r]
				    && (en_q[r] ? c_off[r] : c_on[r])) begin
					if (dly_q[r] == cfg_q[r].delay) begin
						en_q[r]  <= ~en_q[r];
						dly_q[r] <= '0;
					end else if (tick) dly_q[r] <= dly_q[r] + 8'h1;
				end else dly_q[r] <= '0;
			end
		end
	end
	// fault shutdown holds the rail off until its fault flags are cleared
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) foff_q <= '0;
		else begin
			for (int r = 0; r < NR; r++) begin
				if (cfg_q[r].fault_sd && ((|fedge)
				    || (r == int'(sense_rail) && (evt[rs_pkg::S_OVF] | evt[rs_pkg::S_UVF]))))
					foff_q[r] <= 1'b1;
				else if (!st_q[r][rs_pkg::S_OVF] && !st_q[r][rs_pkg::S_UVF] && !infault_q)
					foff_q[r] <= 1'b0;
			end
		end
	end

	// ****************************************
	// good state
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pg_q   <= '0;
			seen_q <= '0;
		end else begin
			for (int r = 0; r < NR; r++) begin
				if (!cfg_q[r].has_sense) pg_q[r] <= en_q[r];
				else if (sv && r == int'(sense_rail)) begin
					if (sense_code > sl[rs_pkg::L_PGON]) pg_q[r] <= 1'b1;
					else if (sense_code < sl[rs_pkg::L_PGOFF]) pg_q[r] <= 1'b0;
				end
				if (!en_q[r]) seen_q[r] <= 1'b0;
				else if (pg_q[r]) seen_q[r] <= 1'b1;
			end
		end
	end

	// ****************************************
	// margin, pin state, outputs
	// ****************************************
	assign mg_on = roles_q.men_en && act[roles_q.men_idx];
	assign mg_lo = roles_q.mlo_en && act[roles_q.mlo_idx];
	always_comb begin
		int n;
		n    = 0;
		ps_d = 3'h0;
		for (int i = 0; i < NR; i++) begin
			if (def_q[i] && n < 3) begin
				ps_d[n] = act[i];
				n = n + 1;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mhi_q      <= '0;
			mlo_q      <= '0;
			ps_q       <= '0;
			alert_oe_b <= 1'b1;
			alert_o    <= 1'b0;
		end else begin
			for (int r = 0; r < NR; r++) begin
				mhi_q[r] <= mg_on & cfg_q[r].margin_en & ~mg_lo;
				mlo_q[r] <= mg_on & cfg_q[r].margin_en & mg_lo;
			end
			ps_q       <= ps_d;
			alert_oe_b <= ~alert_d;
			alert_o    <= 1'b0;
		end
	end
	assign rail_en    = en_q;
	assign margin_hi  = mhi_q;
	assign margin_lo  = mlo_q;
	assign pin_state  = ps_q;
	assign pmbus_fast = fast_q;

	// ****************************************
	// checks
	// ****************************************
	ack_single_a: assert property (wb_ack |=> !wb_ack)
		else $error("ack longer than one cycle");
	both_source_a: assert property (cfg_q[3].mode == rs_pkg::RS_BOTH
		&& !(ctl_s2 && op_q[3]) |=> !$rose(en_q[3])) else $error("combined rail rose unasked");
	en_cond_a: assert property (en_q[0] != $past(en_q[0])
		|-> $past(en_q[0] ? c_off[0] : c_on[0])) else $error("enable moved unready");
	ov_now_a: assert property (sp_wr && cfg_q[sel_q].adaptive_scaling_mode && sp_up
		|=> cur_q[$past(sel_q)][0] == $past(tgt_q[sel_q][0])) else $error("over not loaded");
	pg_set_a: assert property (sv && sense_code > sl[rs_pkg::L_PGON]
		|=> pg_q[$past(sense_rail)]) else $error("good not set");
	pg_nosense_a: assert property (!cfg_q[0].has_sense && $stable(cfg_q[0])
		##1 !cfg_q[0].has_sense |-> pg_q[0] == $past(en_q[0])) else $error("good not tracking");
	uv_mask_a: assert property (evt[rs_pkg::S_UVF]
		|-> en_q[sense_rail] && seen_q[sense_rail]) else $error("under event unmasked");
	in_fault_a: assert property (|fedge |=> infault_q)
		else $error("input fault lost");
	margin_sel_a: assert property (mg_on && mg_lo && cfg_q[0].margin_en
		|=> margin_lo[0] && !margin_hi[0]) else $error("margin low missed");
endmodule // rs_rail_sup

// ==== rs_pkg.sv ====
// rail supervisor constants, register map and shared types
// assumes a 25 MHz system clock and a classic wishbone master
// How it works
// - up to 24 rails, each with sense, enable and margin drive
// - sense samples outside the warn/fault window raise events
// - each rail picks auto, pin, command or combined on/off source
// - combined mode needs control line and operation bit both on
// - dependencies and turn delay are checked before enable moves
// - scaling mode lets software move the setpoint at run time
// - setpoint up: over limits load now, others climb 20 mV per 400 us
// - setpoint down: under and good limits load now, others fall stepwise
// - sensed rail good above good-on, bad below good-off, else held
// - unsensed rail good follows its turn-on and turn-off decision
// - warnings and faults leave good alone unless they shut the rail
// - under events ignored while off and until first good
// - input supply rail low masks under events on all other rails
// - each general input has a programmable active level
// - any general input can be a rail dependency source
// - first three defined inputs drive the pin-selected state
// - a fault-role input going inactive is a fault event
// - a clear-role input clears all latched flags
// - margin-enable input puts margin-enabled rails in margin
// - margin-low input picks low when active, high when not
// - serial side runs at 100 kHz or 400 kHz
// - pending flags pull the open-drain alert line
// - input on-dependency met when active, off-dependency when not
package rs_pkg;
	localparam int NR = 24;
	localparam int LW = 12;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_KHZ   = 25000;
	localparam int STEP_US   = 400;
	localparam int STEP_CYC  = STEP_US * CLK_KHZ / 1000;
	localparam int STEP_MV   = 20;
	localparam int LSB_MV    = 1;
	localparam logic [11:0] STEP_CODE = 12'(STEP_MV / LSB_MV);
	localparam int SPEED_SLOW_HZ = 100000;
	localparam int SPEED_FAST_HZ = 400000;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] R_CTRL  = 8'h00;
	localparam logic [7:0] R_CFG   = 8'h04;
	localparam logic [7:0] R_OPER  = 8'h08;
	localparam logic [7:0] R_POL   = 8'h0c;
	localparam logic [7:0] R_DEF   = 8'h10;
	localparam logic [7:0] R_FROLE = 8'h14;
	localparam logic [7:0] R_CROLE = 8'h18;
	localparam logic [7:0] R_ROLES = 8'h1c;
	localparam logic [7:0] R_SETPT = 8'h28;
	localparam logic [7:0] R_DRAIL = 8'h2c;
	localparam logic [7:0] R_DON   = 8'h30;
	localparam logic [7:0] R_DOFF  = 8'h34;
	localparam logic [7:0] R_STAT  = 8'h38;
	localparam logic [7:0] R_GOOD  = 8'h3c;
	localparam logic [7:0] R_ENAB  = 8'h44;
	localparam logic [7:0] R_LIMB  = 8'h60; // eight limit words
	// limit slots
	localparam int L_OVF = 0, L_OVW = 1, L_UVW = 2, L_UVF = 3;
	localparam int L_PGON = 4, L_PGOFF = 5, L_MHI = 6, L_MLO = 7;
	// status bits
	localparam int S_OVF = 3, S_OVW = 2, S_UVW = 1, S_UVF = 0;
	typedef enum logic [1:0] {
		RS_AUTO = 2'b00,
		RS_PIN  = 2'b01,
		RS_CMD  = 2'b10,
		RS_BOTH = 2'b11
	} rs_mode_e;
	typedef struct packed {
		logic [7:0] delay;
		logic       fault_sd;
		logic       margin_en;
		logic       adaptive_scaling_mode;
		logic       has_sense;
		rs_mode_e   mode;
	} rs_cfg_s;
	typedef struct packed {
		logic       vin_en;
		logic [4:0] vin_rail;
		logic       mlo_en;
		logic [4:0] mlo_idx;
		logic       men_en;
		logic [4:0] men_idx;
	} rs_roles_s;
	typedef logic [7:0][LW-1:0] rs_lim_t;
endpackage

// ==== rs_rail_model.sv ====
// far-side model: the rail sense sampler, one sample per bench request
// assumes the bench pulses go just after a rising clock edge
`timescale 1ns/1ns
module rs_rail_model (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        go,
	input  wire logic [4:0]  rail,
	input  wire logic [11:0] code,
	output logic             sense_valid,
	output logic [4:0]       sense_rail,
	output logic [11:0]      sense_code
);
	// idle lines invert so a stale sample never looks held
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sense_valid <= 1'b0;
			sense_rail  <= 5'h00;
			sense_code  <= 12'h000;
		end else if (go) begin
			sense_valid <= 1'b1;
			sense_rail  <= rail;
			sense_code  <= code;
		end else begin
			sense_valid <= 1'b0;
			sense_rail  <= ~sense_rail;
			sense_code  <= ~sense_code;
		end
	end
endmodule // rs_rail_model

// ==== tb.sv ====
// self-checking bench for the rail supervisor
// assumes a wishbone master, the sense model and bench-driven pins
`timescale 1ns/1ns
module tb;
	localparam int STEP = 10;
	logic        clock, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, control_line, go;
	logic        sense_valid, pmbus_fast, alert_o, alert_oe_b;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_i, wb_dat_o, q, seed, dfm, pol;
	logic [4:0]  sense_rail, s_rail;
	logic [11:0] sense_code, s_code;
	logic [23:0] general_input, rail_en, margin_hi, margin_lo;
	logic [2:0]  pin_state;
	int          err_total, checked;
	int          base [8] = '{3000, 2800, 1200, 1000, 1500, 900, 2200, 1800};

	rs_rail_sup #(.STEP_CYC(STEP)) rs_rail_sup_i (.clock(clock), .rst_b(rst_b),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .sense_valid(sense_valid),
		.sense_rail(sense_rail), .sense_code(sense_code), .control_line(control_line),
		.general_input(general_input), .rail_en(rail_en), .margin_hi(margin_hi),
		.margin_lo(margin_lo), .pin_state(pin_state), .pmbus_fast(pmbus_fast),
		.alert_o(alert_o), .alert_oe_b(alert_oe_b));
	rs_rail_model rs_rail_model_i (.clock(clock), .rst_b(rst_b), .go(go), .rail(s_rail),
		.code(s_code), .sense_valid(sense_valid), .sense_rail(sense_rail),
		.sense_code(sense_code));

	always #20 clock = ~clock;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction
	function automatic logic [31:0] cfg(input logic [1:0] m, input logic s, sc, me);
		return {18'h00000, 8'h00, 1'b0, me, sc, s, m};
	endfunction
	function automatic logic [4:0] exp_st(input int c, input logic armed);
		return {1'b0, c > base[0], c > base[1], armed && c < base[2], armed && c < base[3]};
	endfunction
	// first three defined inputs, active level after polarity
	function automatic logic [2:0] exp_pins(input logic [23:0] d, p, g);
		logic [2:0] r;
		int         k;
		r = 3'h0;
		k = 0;
		for (int i = 0; i < 24; i++) begin
			if (d[i] && k < 3) begin
				r[k] = g[i] ^ p[i];
				k++;
			end
		end
		return r;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_i <= d;
		wb_sel <= 4'hf;
		@(posedge clock);
		while (wb_ack !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) chk(32'h0, 32'h1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic lim(input int k, input int v);
		wr(rs_pkg::R_LIMB + 8'(4 * k), 32'(v));
	endtask
	task automatic wait_en(input int i, input logic v);
		int n;
		n = 0;
		while (rail_en[i] !== v && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk(rail_en[i], v);
	endtask
	task automatic sense(input int c);
		go <= 1'b1;
		s_rail <= 5'h04;
		s_code <= 12'(c);
		@(posedge clock);
		go <= 1'b0;
		repeat (3) @(posedge clock);
		rd(rs_pkg::R_STAT);
	endtask

	initial begin
		#800000;
		err_total++;
		final_report();
	end

	initial begin
		{clock, rst_b, wb_cyc, wb_stb, wb_we, control_line, go} = 7'h00;
		{wb_adr, wb_sel, wb_dat_i, s_rail, s_code, general_input} = '0;
		{err_total, checked} = 0;
		seed = 32'hbb86;
		repeat (2) @(posedge clock);
		chk(rail_en, 0);
		chk(alert_oe_b, 1);
		rst_b <= 1'b1;
		@(posedge clock);
		rd(8'hfc);
		chk(q, 0);
		wr(rs_pkg::R_CTRL, 32'h20);
		chk(pmbus_fast, 1);
		$display("test bus done");
		wr(rs_pkg::R_CTRL, 32'h21);
		wr(rs_pkg::R_CFG, cfg(2'h2, 0, 0, 0));
		wait_en(1, 0);
		wr(rs_pkg::R_OPER, 32'h2);
		wait_en(1, 1);
		wr(rs_pkg::R_CTRL, 32'h22);
		wr(rs_pkg::R_CFG, cfg(2'h1, 0, 0, 0));
		wait_en(2, 0);
		control_line <= 1'b1;
		wait_en(2, 1);
		wr(rs_pkg::R_CTRL, 32'h23);
		wr(rs_pkg::R_CFG, cfg(2'h3, 0, 0, 0));
		for (int i = 0; i < 4; i++) begin
			control_line <= i[0];
			wr(rs_pkg::R_OPER, {28'h0, i[1], 3'h2});
			wait_en(3, i[0] & i[1]);
			repeat (8) @(posedge clock);
			rd(rs_pkg::R_GOOD);
			chk(q[3], i[0] & i[1]);
		end
		control_line <= 1'b0;
		wait_en(3, 0);
		$display("test modes done");
		// sensed rail is taken off and sampled below good-off first so its good state is cleared before turn-on
		wr(rs_pkg::R_CTRL, 32'h24);
		wr(rs_pkg::R_CFG, cfg(2'h2, 1, 0, 0));
		for (int k = 0; k < 8; k++) lim(k, base[k]);
		wait_en(4, 0);
		sense(800);
		chk(q[4:0], exp_st(800, 0));
		wr(rs_pkg::R_OPER, 32'h1a);
		wait_en(4, 1);
		sense(1100);
		chk(q[4:0], exp_st(1100, 0));
		sense(1600);
		rd(rs_pkg::R_GOOD);
		chk(q[4], 1);
		sense(1100);
		chk(q[4:0], exp_st(1100, 1));
		chk(alert_oe_b, 0);
		chk(alert_o, 0);
		rd(rs_pkg::R_GOOD);
		chk(q[4], 1);
		wr(rs_pkg::R_STAT, 32'h0f);
		sense(2900);
		chk(q[4:0], exp_st(2900, 1));
		wr(rs_pkg::R_STAT, 32'h0f);
		repeat (3) @(posedge clock);
		chk(alert_oe_b, 1);
		sense(800);
		rd(rs_pkg::R_GOOD);
		chk(q[4], 0);
		wr(rs_pkg::R_STAT, 32'h0f);
		$display("test sense done");
		// targets wait for the setpoint write, then ramp
		wr(rs_pkg::R_CFG, cfg(2'h0, 1, 1, 0));
		for (int k = 0; k < 8; k++) lim(k, base[k] + 200);
		wr(rs_pkg::R_SETPT, 32'd1200);
		rd(rs_pkg::R_LIMB);
		chk(q, 3200);
		rd(rs_pkg::R_LIMB + 8'h08);
		chk(q <= 1220, 1);
		repeat (200) @(posedge clock);
		rd(rs_pkg::R_LIMB + 8'h08);
		chk(q, 1400);
		for (int k = 0; k < 8; k++) lim(k, base[k]);
		wr(rs_pkg::R_SETPT, 32'd1000);
		rd(rs_pkg::R_LIMB + 8'h10);
		chk(q, 1500);
		rd(rs_pkg::R_LIMB);
		chk(q >= 3180, 1);
		repeat (200) @(posedge clock);
		rd(rs_pkg::R_LIMB + 8'h1c);
		chk(q, 1800);
		$display("test scaling done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			dfm = seed;
			seed = lfsr(seed);
			pol = seed;
			wr(rs_pkg::R_DEF, dfm);
			wr(rs_pkg::R_POL, pol);
			seed = lfsr(seed);
			general_input <= seed[23:0];
			repeat (6) @(posedge clock);
			chk(pin_state, exp_pins(dfm[23:0], pol[23:0], general_input));
		end
		wr(rs_pkg::R_POL, 32'h0);
		$display("test pins done");
		wr(rs_pkg::R_CTRL, 32'h20);
		wr(rs_pkg::R_CFG, cfg(2'h0, 0, 0, 1));
		wr(rs_pkg::R_ROLES, {20'h00000, 1'b1, 5'h06, 1'b1, 5'h05});
		general_input <= 24'h000060;
		repeat (8) @(posedge clock);
		chk({margin_hi[0], margin_lo[0]}, 2'b01);
		general_input <= 24'h000020;
		repeat (8) @(posedge clock);
		chk({margin_hi[0], margin_lo[0]}, 2'b10);
		general_input <= 24'h000080;
		repeat (8) @(posedge clock);
		chk({margin_hi[0], margin_lo[0]}, 2'b00);
		$display("test margin done");
		wr(rs_pkg::R_FROLE, 32'h80);
		rd(rs_pkg::R_STAT);
		chk(q[4], 0);
		general_input <= 24'h000000;
		repeat (8) @(posedge clock);
		rd(rs_pkg::R_STAT);
		chk(q[4], 1);
		wr(rs_pkg::R_CROLE, 32'h100);
		general_input <= 24'h000180;
		repeat (8) @(posedge clock);
		rd(rs_pkg::R_STAT);
		chk(q[4], 0);
		$display("test roles done");
		// command-mode rail with a two-tick turn delay and an input on-dependency
		wr(rs_pkg::R_CTRL, 32'h25);
		wr(rs_pkg::R_CFG, 32'h82);
		wait_en(5, 0);
		wr(rs_pkg::R_DON, 32'h200);
		wr(rs_pkg::R_OPER, 32'h3a);
		repeat (40) @(posedge clock);
		chk(rail_en[5], 0);
		general_input <= 24'h000380;
		repeat (8) @(posedge clock);
		chk(rail_en[5], 0);
		wait_en(5, 1);
		$display("test dependency done");
		final_report();
	end
endmodule // tb
